/* verilog/ebp_pkg.sv */
// package of constants and types for the external bus pin sharing layer
package ebp_pkg;
	// =========================================================================
	// widths
	localparam int ADDR_W = 26;
	localparam int DATA_W = 32;
	localparam int BOOT_W = 4;
	localparam int CS_W = 6;
	// =========================================================================
	// field positions on the address pins
	localparam int FLAT_BANK_LSB = 16;
	localparam int FLAT_BANK_W = 5;
	localparam int ILV_BANK_LSB = 21;
	localparam int ILV_BANK_W = 4;
	localparam int ROWCOL_LSB = 1;
	localparam int ROWCOL_PIN_W = 10;
	localparam int ROWCOL_W = 12;
	// =========================================================================
	// chip select pin indices
	localparam int CS_SDRAM0_IDX = 2;
	localparam int CS_SDRAM1_IDX = 3;
	localparam int CS_DATA_ACKNOWLEDGE_IN_IDX = 4;
	// =========================================================================
	// reset values
	localparam logic SDRAM_CS_SEL_RST = 1'h1;
	localparam logic [3:0] BOOT_RST = 4'h0;
	// =========================================================================
	// burst clock divider: half period in system clock cycles
	localparam int BCLK_HALF_CYC = 2;
	// =========================================================================
	// which controller owns the shared pins
	typedef enum logic [1:0] {
		OWN_STATIC,
		OWN_SDRAM,
		OWN_CARD
	} ebp_owner_type;
	// burst sequencer states
	typedef enum logic [1:0] {
		BST_IDLE,
		BST_LATCH,
		BST_RUN
	} ebp_bst_type;
endpackage

/* verilog/ebp_burst_ctl.sv */
// burst flash control: address latch, burst clock, restart handling
`timescale 1ns/10ps
module ebp_burst_ctl import ebp_pkg::*; #(
	parameter int HALF_CYC = BCLK_HALF_CYC
) (
	input wire logic i_clk, // system clock
	input wire logic i_nrst, // async reset, active low
	input wire logic i_start, // begin a burst
	input wire logic i_stop, // end the burst
	input wire logic i_restart_n, // restart request from flash
	output logic o_lba_n, // address latch strobe
	output logic o_bclk, // burst clock
	output logic o_long_first, // next access is a long first access
	output logic o_active // burst in progress
);
	// =========================================================================
	// state
	ebp_bst_type st_q, st_d;
	logic [7:0] div_q, div_d;
	logic bclk_q, bclk_d;
	logic long_q, long_d;

	always_comb begin
		st_d = st_q;
		div_d = div_q;
		bclk_d = 1'b0;
		long_d = long_q;
		case (st_q)
			BST_IDLE: begin
				div_d = 8'h00;
				if (i_start) begin
					st_d = BST_LATCH;
					long_d = 1'b1;
				end
			end
			BST_LATCH: begin
				st_d = BST_RUN;
				div_d = 8'h00;
			end
			BST_RUN: begin
				bclk_d = bclk_q;
				if (div_q == 8'(HALF_CYC - 1)) begin
					div_d = 8'h00;
					bclk_d = ~bclk_q;
					if (bclk_q) begin
						long_d = 1'b0;
					end
				end else begin
					div_d = div_q + 8'h01;
				end
				if (i_stop) begin
					st_d = BST_IDLE;
					bclk_d = 1'b0;
				end else if (!i_restart_n) begin
					st_d = BST_LATCH;
					bclk_d = 1'b0;
					long_d = 1'b1;
				end
			end
			default: st_d = BST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_q <= BST_IDLE;
			div_q <= 8'h00;
			bclk_q <= 1'b0;
			long_q <= 1'b0;
		end else begin
			st_q <= st_d;
			div_q <= div_d;
			bclk_q <= bclk_d;
			long_q <= long_d;
		end
	end

	assign o_lba_n = (st_q != BST_LATCH);
	assign o_bclk = bclk_q;
	assign o_long_first = long_q;
	assign o_active = (st_q != BST_IDLE);
endmodule // ebp_burst_ctl

/* verilog/ebp_pin_mux.sv */
// pin sharing layer between on-chip memory controllers and external bus pins
// Notes on behaviour
// - strobe 0, active low, gates D[31:24]; carries SDRAM mask 0 too.
// - strobe 1, active low, gates D[23:16]; carries SDRAM mask 1 too.
// - strobe 2, active low, D[15:8]; shares mask 2 and card attribute select.
// - strobe 3, active low, D[7:0]; shares mask 3 and card I/O read.
// - active-low read output enable; same pin is card I/O write strobe.
// - six chip selects; 3 and 2 may be SDRAM selects, SDRAM after reset.
// - chip select 4 pin may instead be a data acknowledge input.
// - burst restart request aborts burst; new burst starts with long first access.
// - address latch strobe makes flash capture burst start address.
// - burst clock driven to synchronous memories during burst mode.
// - direction high for read, low for write; pin is card write enable.
// - boot mode taken from four boot pins at reset; board keeps them steady.
// - flat SDRAM bank address on A[20:16] in non-interleaved mode.
// - interleaved SDRAM bank address on A[24:21].
// - twelve-bit SDRAM row/column address; low ten bits on A[10:1].
`timescale 1ns/10ps
module ebp_pin_mux import ebp_pkg::*; #(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W
) (
	input wire logic I_SYS_CLK, // system clock, 250 MHz
	input wire logic I_NRST, // async reset, active low
	// ownership and configuration
	input wire logic [1:0] I_OWNER, // owner of shared pins (ebp_owner_type)
	input wire logic I_SDRAM_CS_SEL, // mux control: 1 selects sdram chip selects
	input wire logic I_DATA_ACKNOWLEDGE_IN_SEL, // 1: chip select 4 pin is data acknowledge
	input wire logic I_SDRAM_INTERLEAVE, // 1: interleaved bank addressing
	// static memory controller
	input wire logic [AW-1:0] I_ST_ADDR, // static address
	input wire logic [3:0] I_ST_BE, // byte enables, bit 0 = D[31:24], active high
	input wire logic I_ST_READ, // read cycle
	input wire logic I_ST_ACTIVE, // access in progress
	input wire logic I_ST_OE, // output enable request
	input wire logic [CS_W-1:0] I_ST_CS, // chip select requests, active high
	input wire logic [DW-1:0] I_ST_WDATA, // write data
	input wire logic I_BURST_START, // begin burst
	input wire logic I_BURST_STOP, // end burst
	output logic O_BURST_LONG_FIRST, // next burst access is long first access
	output logic O_BURST_ACTIVE, // burst in progress
	output logic O_ST_DATA_ACKNOWLEDGE_IN, // data acknowledge seen
	output logic [DW-1:0] O_RDATA, // captured read data
	// sdram controller
	input wire logic [4:0] I_SD_FLAT_BANK, // flat bank address
	input wire logic [3:0] I_SD_ILV_BANK, // interleave bank address
	input wire logic [ROWCOL_W-1:0] I_SD_ROWCOL, // row/column address
	input wire logic [3:0] I_SD_DQM, // data masks, bit 0 = D[31:24]
	input wire logic [1:0] I_SD_CS, // sdram chip select requests, active high
	input wire logic I_SD_READ, // read cycle
	input wire logic I_SD_ACTIVE, // access in progress
	input wire logic [DW-1:0] I_SD_WDATA, // write data
	output logic [1:0] O_SD_ROWCOL_HI, // row/column bits above pin field
	// card interface
	input wire logic I_PC_ATTR, // attribute space select
	input wire logic I_CARD_IO_READ_N, // io read request
	input wire logic I_CARD_IO_WRITE_N, // io write request
	input wire logic I_CARD_WRITE_ENABLE_N, // write enable request
	input wire logic [AW-1:0] I_PC_ADDR, // card address
	// pins
	output logic [AW-1:0] O_ADDR, // address pins
	input wire logic [DW-1:0] I_DATA, // data pins in
	output logic [DW-1:0] O_DATA, // data pins out
	output logic O_DATA_OE, // data pins drive enable
	output logic [3:0] O_BYTE_LANE_STROBE_N, // strobes / dqm / card strobes
	output logic O_OE_N, // output enable / card io write
	output logic O_RW, // direction / card write enable
	output logic [CS_W-1:0] O_CS_N, // chip selects
	output logic O_CS_N_OE, // chip select pins drive enable, bit 4 excepted
	output logic O_CS4_OE, // chip select 4 pin drive enable
	input wire logic I_CS4_DATA_ACKNOWLEDGE_IN, // chip select 4 pin in (data acknowledge)
	input wire logic I_BURST_RESTART_REQUEST_N, // restart from flash
	output logic O_BURST_ADDRESS_LATCH_N, // address latch strobe
	output logic O_BCLK, // burst clock
	input wire logic [BOOT_W-1:0] I_BOOT, // boot select pins
	output logic [BOOT_W-1:0] O_BOOT_MODE // captured boot mode
);
	// =========================================================================
	// pin output decode
	ebp_owner_type owner;
	logic [AW-1:0] addr_d, addr_q;
	logic [DW-1:0] wdata_d, wdata_q, rdata_d, rdata_q;
	logic doe_d, doe_q;
	logic [3:0] strobe_d, strobe_q;
	logic oe_d, oe_q, rw_d, rw_q, data_acknowledge_in_d, data_acknowledge_in_q;
	logic [CS_W-1:0] cs_d, cs_q;
	logic cs4_oe_d, cs4_oe_q;
	logic boot_done_q, boot_done_d;
	logic [BOOT_W-1:0] boot_q, boot_d;

	assign owner = ebp_owner_type'(I_OWNER);

	function automatic logic [AW-1:0] sd_addr(input logic ilv, input logic [4:0] fb,
		input logic [3:0] ib, input logic [ROWCOL_W-1:0] rc);
		logic [AW-1:0] a;
		a = '0;
		a[ROWCOL_LSB +: ROWCOL_PIN_W] = rc[ROWCOL_PIN_W-1:0];
		if (ilv) begin
			a[ILV_BANK_LSB +: ILV_BANK_W] = ib;
		end else begin
			a[FLAT_BANK_LSB +: FLAT_BANK_W] = fb;
		end
		return a;
	endfunction

	always_comb begin
		addr_d = '0;
		wdata_d = '0;
		doe_d = 1'b0;
		strobe_d = 4'hF;
		oe_d = 1'b1;
		rw_d = 1'b1;
		cs_d = {CS_W{1'b1}};
		case (owner)
			OWN_STATIC: begin
				addr_d = I_ST_ADDR;
				if (I_ST_ACTIVE) begin
					strobe_d = ~I_ST_BE;
					oe_d = ~(I_ST_OE & I_ST_READ);
					rw_d = I_ST_READ;
					doe_d = ~I_ST_READ;
					wdata_d = I_ST_WDATA;
					cs_d = ~I_ST_CS;
				end
			end
			OWN_SDRAM: begin
				addr_d = sd_addr(I_SDRAM_INTERLEAVE, I_SD_FLAT_BANK, I_SD_ILV_BANK, I_SD_ROWCOL);
				if (I_SD_ACTIVE) begin
					strobe_d = I_SD_DQM;
					rw_d = I_SD_READ;
					doe_d = ~I_SD_READ;
					wdata_d = I_SD_WDATA;
				end
			end
			OWN_CARD: begin
				addr_d = I_PC_ADDR;
				strobe_d[2] = ~I_PC_ATTR;
				strobe_d[3] = ~I_CARD_IO_READ_N;
				oe_d = ~I_CARD_IO_WRITE_N;
				rw_d = ~I_CARD_WRITE_ENABLE_N;
				doe_d = I_CARD_IO_WRITE_N | I_CARD_WRITE_ENABLE_N;
				wdata_d = I_ST_WDATA;
			end
			default: begin
			end
		endcase
		// chip selects 3 and 2 follow the mux control
		if (I_SDRAM_CS_SEL) begin
			cs_d[CS_SDRAM0_IDX] = ~(owner == OWN_SDRAM && I_SD_ACTIVE && I_SD_CS[0]);
			cs_d[CS_SDRAM1_IDX] = ~(owner == OWN_SDRAM && I_SD_ACTIVE && I_SD_CS[1]);
		end
		cs4_oe_d = ~I_DATA_ACKNOWLEDGE_IN_SEL;
		if (I_DATA_ACKNOWLEDGE_IN_SEL) begin
			cs_d[CS_DATA_ACKNOWLEDGE_IN_IDX] = 1'b1;
		end
		data_acknowledge_in_d = I_DATA_ACKNOWLEDGE_IN_SEL & I_CS4_DATA_ACKNOWLEDGE_IN;
		rdata_d = rdata_q;
		if (!oe_q || (owner == OWN_SDRAM && I_SD_READ && I_SD_ACTIVE)) begin
			rdata_d = I_DATA;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			addr_q <= '0;
			wdata_q <= '0;
			rdata_q <= '0;
			doe_q <= 1'b0;
			strobe_q <= 4'hF;
			oe_q <= 1'b1;
			rw_q <= 1'b1;
			cs_q <= {CS_W{1'b1}};
			cs4_oe_q <= 1'b1;
			data_acknowledge_in_q <= 1'b0;
		end else begin
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
			doe_q <= doe_d;
			strobe_q <= strobe_d;
			oe_q <= oe_d;
			rw_q <= rw_d;
			cs_q <= cs_d;
			cs4_oe_q <= cs4_oe_d;
			data_acknowledge_in_q <= data_acknowledge_in_d;
		end
	end

	// =========================================================================
	// boot mode capture, once at the first edge after reset release
	always_comb begin
		boot_d = boot_q;
		boot_done_d = 1'b1;
		if (!boot_done_q) begin
			boot_d = I_BOOT;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			boot_q <= BOOT_RST;
			boot_done_q <= 1'b0;
		end else begin
			boot_q <= boot_d;
			boot_done_q <= boot_done_d;
		end
	end

	// =========================================================================
	// burst sequencer
	ebp_burst_ctl #(
		.HALF_CYC(BCLK_HALF_CYC)
	) u_burst (
		.i_clk(I_SYS_CLK),
		.i_nrst(I_NRST),
		.i_start(I_BURST_START & (owner == OWN_STATIC)),
		.i_stop(I_BURST_STOP),
		.i_restart_n(I_BURST_RESTART_REQUEST_N),
		.o_lba_n(O_BURST_ADDRESS_LATCH_N),
		.o_bclk(O_BCLK),
		.o_long_first(O_BURST_LONG_FIRST),
		.o_active(O_BURST_ACTIVE)
	);

	assign O_ADDR = addr_q;
	assign O_DATA = wdata_q;
	assign O_DATA_OE = doe_q;
	assign O_RDATA = rdata_q;
	assign O_BYTE_LANE_STROBE_N = strobe_q;
	assign O_OE_N = oe_q;
	assign O_RW = rw_q;
	assign O_CS_N = cs_q;
	assign O_CS_N_OE = 1'b1;
	assign O_CS4_OE = cs4_oe_q;
	assign O_ST_DATA_ACKNOWLEDGE_IN = data_acknowledge_in_q;
	assign O_BOOT_MODE = boot_q;
	assign O_SD_ROWCOL_HI = I_SD_ROWCOL[ROWCOL_W-1 -: 2];
endmodule // ebp_pin_mux

/* tb/ebp_pin_mux_properties.sv */
// concurrent checks on the pin sharing layer ports
`timescale 1ns/10ps
module ebp_pin_mux_properties import ebp_pkg::*; (
	input wire logic I_SYS_CLK, // clk
	input wire logic I_NRST, // rst
	input wire logic [1:0] I_OWNER, // owner
	input wire logic I_SDRAM_CS_SEL, // cs mux
	input wire logic I_DATA_ACKNOWLEDGE_IN_SEL, // ack mux
	input wire logic I_SDRAM_INTERLEAVE, // bank mode
	input wire logic [3:0] I_ST_BE, // static
	input wire logic I_ST_READ, // static
	input wire logic I_ST_ACTIVE, // static
	input wire logic I_ST_OE, // static
	input wire logic [4:0] I_SD_FLAT_BANK, // sdram
	input wire logic [3:0] I_SD_ILV_BANK, // sdram
	input wire logic [ROWCOL_W-1:0] I_SD_ROWCOL, // sdram
	input wire logic [3:0] I_SD_DQM, // sdram
	input wire logic [1:0] I_SD_CS, // sdram
	input wire logic I_SD_ACTIVE, // sdram
	input wire logic I_PC_ATTR, // card
	input wire logic I_CARD_IO_READ_N, // card
	input wire logic I_CARD_IO_WRITE_N, // card
	input wire logic I_CARD_WRITE_ENABLE_N, // card
	input wire logic I_BURST_STOP, // burst
	input wire logic I_CS4_DATA_ACKNOWLEDGE_IN, // pin
	input wire logic I_BURST_RESTART_REQUEST_N, // pin
	input logic [ADDR_W-1:0] O_ADDR, // pin
	input logic [3:0] O_BYTE_LANE_STROBE_N, // pin
	input logic O_OE_N, // pin
	input logic O_RW, // pin
	input logic [CS_W-1:0] O_CS_N, // pin
	input logic O_CS4_OE, // pin
	input logic O_ST_DATA_ACKNOWLEDGE_IN, // ack
	input logic O_BURST_ADDRESS_LATCH_N, // pin
	input logic O_BCLK, // pin
	input logic O_BURST_ACTIVE, // burst
	input logic O_BURST_LONG_FIRST // burst
);
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_NRST);
	// =========================================================================
	// pin mapping
	property p_st_pins;
		$past(I_OWNER == 2'h0 && I_ST_ACTIVE) |-> O_BYTE_LANE_STROBE_N == ~$past(I_ST_BE)
			&& O_RW == $past(I_ST_READ) && O_OE_N == !($past(I_ST_OE) && $past(I_ST_READ));
	endproperty
	a_st_pins: assert property (p_st_pins) else $error("static strobe or direction wrong");
	property p_sd_flat;
		$past(I_OWNER == 2'h1 && I_SD_ACTIVE && !I_SDRAM_INTERLEAVE) |-> O_ADDR[20:16] == $past(I_SD_FLAT_BANK)
			&& O_ADDR[10:1] == $past(I_SD_ROWCOL[9:0]) && O_BYTE_LANE_STROBE_N == $past(I_SD_DQM);
	endproperty
	a_sd_flat: assert property (p_sd_flat) else $error("flat sdram address wrong");
	property p_sd_ilv;
		$past(I_OWNER == 2'h1 && I_SD_ACTIVE && I_SDRAM_INTERLEAVE) |-> O_ADDR[24:21] == $past(I_SD_ILV_BANK);
	endproperty
	a_sd_ilv: assert property (p_sd_ilv) else $error("interleave bank wrong");
	property p_sd_cs;
		$past(I_OWNER == 2'h1 && I_SD_ACTIVE && I_SDRAM_CS_SEL) |-> O_CS_N[3:2] == ~$past(I_SD_CS);
	endproperty
	a_sd_cs: assert property (p_sd_cs) else $error("sdram select wrong");
	property p_card;
		$past(I_OWNER == 2'h2) |-> O_BYTE_LANE_STROBE_N == {!$past(I_CARD_IO_READ_N), !$past(I_PC_ATTR), 2'h3}
			&& O_OE_N == !$past(I_CARD_IO_WRITE_N) && O_RW == !$past(I_CARD_WRITE_ENABLE_N);
	endproperty
	a_card: assert property (p_card) else $error("card strobes wrong");
	property p_data_acknowledge_in;
		$past(I_DATA_ACKNOWLEDGE_IN_SEL) |-> !O_CS4_OE && O_CS_N[4] && O_ST_DATA_ACKNOWLEDGE_IN == $past(I_CS4_DATA_ACKNOWLEDGE_IN);
	endproperty
	a_data_acknowledge_in: assert property (p_data_acknowledge_in) else $error("acknowledge pin wrong");
	// =========================================================================
	// burst control
	property p_lba;
		$rose(O_BURST_ACTIVE) |-> !O_BURST_ADDRESS_LATCH_N && O_BURST_LONG_FIRST ##1 O_BURST_ADDRESS_LATCH_N;
	endproperty
	a_lba: assert property (p_lba) else $error("latch strobe not one cycle");
	property p_restart;
		O_BURST_ACTIVE && O_BURST_ADDRESS_LATCH_N && !I_BURST_RESTART_REQUEST_N && !I_BURST_STOP
			|=> !O_BURST_ADDRESS_LATCH_N && O_BURST_LONG_FIRST && !O_BCLK;
	endproperty
	a_restart: assert property (p_restart) else $error("restart not honoured");
	property p_bclk;
		!O_BURST_ACTIVE |-> !O_BCLK;
	endproperty
	a_bclk: assert property (p_bclk) else $error("burst clock outside burst");
	c_burst: cover property ($rose(O_BURST_ACTIVE));
	c_restart: cover property (O_BURST_ACTIVE && !I_BURST_RESTART_REQUEST_N);
	c_card: cover property (I_OWNER == 2'h2 && I_PC_ATTR);
endmodule // ebp_pin_mux_properties
bind ebp_pin_mux ebp_pin_mux_properties i_ebp_pin_mux_properties (.*);

/* tb/ebp_flash_model.sv */
// far side model: flash data, acknowledge and restart
`timescale 1ns/10ps
module ebp_flash_model import ebp_pkg::*; (
	input wire logic i_clk, // clock
	input wire logic i_oe_n, // read enable pin
	input wire logic i_cs4_oe, // cs4 drive enable
	input wire logic i_cs4_n, // cs4 driven level
	input wire logic i_ack, // bench: acknowledge
	input wire logic i_abort, // bench: request burst restart
	input wire logic [DATA_W-1:0] i_word, // word returned
	output logic [DATA_W-1:0] o_data, // data pins
	output logic o_cs4, // cs4 wire level
	output logic o_restart_n // restart request
);
	logic [DATA_W-1:0] last_q = '0;
	always_ff @(posedge i_clk) last_q <= o_data;
	// released bus never repeats the last word
	assign o_data = !i_oe_n ? i_word : ~last_q;
	assign o_cs4 = i_cs4_oe ? i_cs4_n : i_ack;
	assign o_restart_n = !i_abort;
endmodule // ebp_flash_model

/* tb/ebp_pin_mux_tb.sv */
// self-checking bench for the pin sharing layer
`timescale 1ns/10ps
module ebp_pin_mux_tb import ebp_pkg::*;;
	logic clk, nrst, cssel, dsel, ilv, rd, act, oe, bst, bsp, srd, sact, attr, iord, iowr, we, ack, abrt;
	logic [1:0] own, scs, rchi;
	logic [3:0] be, ib, dqm, boot, stb, bmode;
	logic [4:0] fb;
	logic [5:0] cs, csn;
	logic [11:0] rc;
	logic [25:0] sta, addr;
	logic [31:0] wd, word, dout, rdat, din;
	logic doe, oen, rw, cs4oe, lban, bclk, dtk, lf, bact, cs4, rstn;
	int error_cnt = 0;
	int n_tests = 0;
	ebp_pin_mux i_ebp_pin_mux (.I_SYS_CLK(clk), .I_NRST(nrst), .I_OWNER(own), .I_SDRAM_CS_SEL(cssel),
		.I_DATA_ACKNOWLEDGE_IN_SEL(dsel), .I_SDRAM_INTERLEAVE(ilv), .I_ST_ADDR(sta), .I_ST_BE(be), .I_ST_READ(rd),
		.I_ST_ACTIVE(act), .I_ST_OE(oe), .I_ST_CS(cs), .I_ST_WDATA(wd), .I_BURST_START(bst),
		.I_BURST_STOP(bsp), .O_BURST_LONG_FIRST(lf), .O_BURST_ACTIVE(bact), .O_ST_DATA_ACKNOWLEDGE_IN(dtk),
		.O_RDATA(rdat), .I_SD_FLAT_BANK(fb), .I_SD_ILV_BANK(ib), .I_SD_ROWCOL(rc), .I_SD_DQM(dqm),
		.I_SD_CS(scs), .I_SD_READ(srd), .I_SD_ACTIVE(sact), .I_SD_WDATA(32'h0), .O_SD_ROWCOL_HI(rchi),
		.I_PC_ATTR(attr), .I_CARD_IO_READ_N(iord), .I_CARD_IO_WRITE_N(iowr), .I_CARD_WRITE_ENABLE_N(we), .I_PC_ADDR(26'h0),
		.O_ADDR(addr), .I_DATA(din), .O_DATA(dout), .O_DATA_OE(doe), .O_BYTE_LANE_STROBE_N(stb),
		.O_OE_N(oen), .O_RW(rw), .O_CS_N(csn), .O_CS_N_OE(), .O_CS4_OE(cs4oe), .I_CS4_DATA_ACKNOWLEDGE_IN(cs4),
		.I_BURST_RESTART_REQUEST_N(rstn), .O_BURST_ADDRESS_LATCH_N(lban), .O_BCLK(bclk),
		.I_BOOT(boot), .O_BOOT_MODE(bmode));
	ebp_flash_model i_ebp_flash_model (.i_clk(clk), .i_oe_n(oen), .i_cs4_oe(cs4oe), .i_cs4_n(csn[4]),
		.i_ack(ack), .i_abort(abrt), .i_word(word), .o_data(din), .o_cs4(cs4), .o_restart_n(rstn));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// =========================================================================
	// helpers
	task automatic step();
		@(posedge clk) #1;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// =========================================================================
	// scenarios
	task automatic t_static();
		{own, act, rd, be, cs, cssel, sta, wd} = {2'h0, 2'b10, 4'h5, 6'h01, 1'b0, 26'h2A5A5A5, 32'hA5C30F96};
		step(); step();
		chk({stb, rw, doe, csn}, {4'hA, 2'b01, 6'h3E});
		chk(addr, sta);
		chk(dout, wd);
		{rd, oe, word} = {2'b11, 32'h12345678};
		step(); step();
		chk({oen, rw, doe}, 3'b010);
		chk(rdat, word);
		{act, rd, oe} = 3'b000;
	endtask
	task automatic t_sdram();
		{own, sact, cssel, scs, dqm, fb, ib, rc} = {2'h1, 2'b11, 2'h2, 4'h6, 5'h15, 4'h9, 12'hABC};
		for (int i = 0; i < 2; i++) begin
			ilv = i[0];
			step(); step();
			chk(addr, ({16'h0, rc[9:0]} << 1) | (ilv ? {22'h0, ib} << 21 : {21'h0, fb} << 16));
			chk({stb, oen, csn[3:2], rchi}, {dqm, 1'b1, ~scs, rc[11:10]});
		end
		sact = 1'b0;
	endtask
	task automatic t_card();
		own = 2'h2;
		for (int i = 0; i < 4; i++) begin
			{attr, iord, iowr, we} = 4'h8 >> i;
			step(); step();
			chk({stb, oen, rw}, {~iord, ~attr, 2'h3, ~iowr, ~we});
		end
	endtask
	task automatic t_data_acknowledge_in();
		{own, dsel, ack} = {2'h3, 2'b11};
		step(); step();
		chk({cs4oe, csn[4], dtk}, 3'b011);
		ack = 1'b0;
		step(); step();
		chk(dtk, 1'b0);
		dsel = 1'b0;
	endtask
	task automatic t_burst();
		{own, bst} = 3'b001;
		step();
		bst = 1'b0;
		chk({lban, lf, bact}, 3'b011);
		step();
		chk(lban, 1'b1);
		for (int k = 0; k < 8 && bclk !== 1'b1; k++) step();
		chk(bclk, 1'b1);
		if (bclk !== 1'b1) print_verdict();
		abrt = 1'b1;
		step();
		abrt = 1'b0;
		chk({lban, lf, bclk}, 3'b010);
		step(); step();
		bsp = 1'b1;
		step();
		bsp = 1'b0;
		chk({bact, bclk}, 2'b00);
	endtask
	// =========================================================================
	// main sequence
	initial begin
		{nrst, own, cssel, dsel, ilv, rd, act, oe, bst, bsp, srd, sact, attr, iord, iowr, we, ack, abrt} = 19'h08000;
		{be, ib, dqm, fb, cs, scs, rc, sta, wd, word} = '0;
		boot = 4'h5;
		repeat (4) @(posedge clk);
		#1 chk({stb, oen, rw, csn, cs4oe, doe}, {4'hF, 2'b11, 6'h3F, 2'b10});
		nrst = 1'b1;
		step();
		chk(bmode, 4'h5);
		boot = 4'h2;
		step(); step();
		chk(bmode, 4'h5);
		t_static();
		t_sdram();
		t_card();
		t_data_acknowledge_in();
		t_burst();
		print_verdict();
	end
endmodule // ebp_pin_mux_tb
